// File: core/eblk_pkg.sv
// Shared constants and types for the embedded block RAM.
package eblk_pkg;
   // Storage geometry: 512 words of 18 bits is the widest packing.
   localparam int unsigned MEM_BITS   = 9216;
   localparam int unsigned BASE_W     = 14;
   localparam int unsigned ADDR_W     = 13;
   localparam int unsigned MAX_DW     = 18;
   // Legal port widths and their depths.
   localparam int unsigned DW_1       = 1;
   localparam int unsigned DW_2       = 2;
   localparam int unsigned DW_4       = 4;
   localparam int unsigned DW_9       = 9;
   localparam int unsigned DW_18      = 18;
   localparam int unsigned DEPTH_1    = 8192;
   localparam int unsigned DEPTH_2    = 4096;
   localparam int unsigned DEPTH_4    = 2048;
   localparam int unsigned DEPTH_9    = 1024;
   localparam int unsigned DEPTH_18   = 512;
   // Preload image layout in the user flash store.
   localparam int unsigned INIT_DW    = 9;
   localparam int unsigned INIT_WORDS = 1024;
   localparam int unsigned FLASH_AW   = 16;
   localparam logic [ADDR_W-1:0] INIT_LAST = 13'h03ff;

   typedef enum logic [1:0] {
      EBLK_SINGLE,
      EBLK_TRUE_DUAL,
      EBLK_PSEUDO_DUAL,
      EBLK_FIFO
   } eblk_mode_e;

   typedef enum logic {
      EBLK_ST_LOAD,
      EBLK_ST_RUN
   } eblk_state_e;

   function automatic int unsigned eblk_depth(input int unsigned dw);
      case (dw)
         DW_1:    return DEPTH_1;
         DW_2:    return DEPTH_2;
         DW_4:    return DEPTH_4;
         DW_9:    return DEPTH_9;
         DW_18:   return DEPTH_18;
         default: return 0;
      endcase
   endfunction
endpackage

// File: core/eblk_ram.sv
// Embedded block RAM: single, true dual, pseudo dual and FIFO modes with flash preload.
// Summary of operation
// - Port widths of 1, 2, 4 and 9 bits work in every mode, and 18 bits only in pseudo dual and FIFO.
// - In true dual and pseudo dual modes each port has its own width and depth over one shared array.
// - Word n of width W sits at storage bits n*W up to n*W+W-1, LSB first, for every port.
// - After reset the block can preload its contents from the user flash store before use.
// - An all-zero image reads no flash, and blocks naming the same image base share one image.
// - Address, data and write controls of each port are registered before the array.
// - An optional output register per port adds one cycle of read latency.
module eblk_ram #(
   parameter eblk_pkg::eblk_mode_e      MODE            = eblk_pkg::EBLK_TRUE_DUAL,
   parameter int unsigned               DW_A            = 9,
   parameter int unsigned               DW_B            = 9,
   parameter bit                        OUT_REG_A       = 1'b0,
   parameter bit                        OUT_REG_B       = 1'b0,
   parameter bit                        INIT_FROM_FLASH = 1'b0,
   parameter logic [15:0]               INIT_IMAGE_BASE = 16'h0000
) (
   input  wire logic                          clk,           // Port clock shared by both ports
   input  wire logic                          rst_n,         // Synchronous reset, active low
   input  wire logic                          en_a,          // Port A access enable
   input  wire logic                          we_a,          // Port A write, or FIFO push
   input  wire logic [eblk_pkg::ADDR_W-1:0]   addr_a,        // Port A word address
   input  wire logic [DW_A-1:0]               wdata_a,       // Port A write data
   output logic      [DW_A-1:0]               rdata_a,       // Port A read data
   input  wire logic                          en_b,          // Port B access enable, or FIFO pop
   input  wire logic                          we_b,          // Port B write
   input  wire logic [eblk_pkg::ADDR_W-1:0]   addr_b,        // Port B word address
   input  wire logic [DW_B-1:0]               wdata_b,       // Port B write data
   output logic      [DW_B-1:0]               rdata_b,       // Port B read data
   output logic                               fifo_full,     // FIFO holds no room for a push
   output logic                               fifo_empty,    // FIFO holds no word to pop
   output logic                               ready,         // Preload finished, ports live
   output logic                               cfg_error,     // Width not legal in this mode
   output logic                               flash_req,     // Request one preload word
   output logic      [eblk_pkg::FLASH_AW-1:0] flash_addr,    // Preload word address in flash
   input  wire logic                          flash_ack,     // Preload word present this cycle
   input  wire logic [eblk_pkg::INIT_DW-1:0]  flash_data     // Preload word from flash
);
   localparam int unsigned DEPTH_A = eblk_pkg::eblk_depth(DW_A);
   localparam int unsigned DEPTH_B = eblk_pkg::eblk_depth(DW_B);
   localparam bit MULTI = (MODE != eblk_pkg::EBLK_SINGLE);
   localparam bit FIFO  = (MODE == eblk_pkg::EBLK_FIFO);
   localparam bit PDP   = (MODE == eblk_pkg::EBLK_PSEUDO_DUAL);
   // The FIFO uses the push width on both ends so the pointers stay in one word unit.
   localparam int unsigned FDEPTH = DEPTH_A;

   localparam bit WIDE_OK = PDP || FIFO;
   localparam bit LEGAL_A = (DEPTH_A != 0) && ((DW_A != eblk_pkg::DW_18) || WIDE_OK);
   localparam bit LEGAL_B = (DEPTH_B != 0) && ((DW_B != eblk_pkg::DW_18) || WIDE_OK);
   localparam bit LEGAL   = LEGAL_A && (!MULTI || LEGAL_B) && (!FIFO || DW_A == DW_B);

   logic [eblk_pkg::MEM_BITS-1:0] mem_q;
   eblk_pkg::eblk_state_e          state_q;
   logic [eblk_pkg::ADDR_W-1:0]    init_cnt_q;
   logic                           ready_q;
   logic                           flash_req_q;
   logic [eblk_pkg::FLASH_AW-1:0]  flash_addr_q;

   logic                           en_a_q, we_a_q, en_b_q, we_b_q;
   logic [eblk_pkg::ADDR_W-1:0]    addr_a_q, addr_b_q;
   logic [DW_A-1:0]                wdata_a_q;
   logic [DW_B-1:0]                wdata_b_q;
   logic [DW_A-1:0]                rd_a_q, rdata_a_q;
   logic [DW_B-1:0]                rd_b_q, rdata_b_q;

   logic [eblk_pkg::ADDR_W-1:0]    wp_q, rp_q;
   logic [eblk_pkg::ADDR_W:0]      cnt_q;
   logic                           full_q, empty_q;

   // FIFO pointer and level update from the registered push and pop.
   wire logic push_ok = FIFO && ready_q && en_a_q && we_a_q && !full_q;
   wire logic pop_ok  = FIFO && ready_q && en_b_q && !empty_q;
   wire logic [eblk_pkg::ADDR_W:0] cnt_d = cnt_q + {{eblk_pkg::ADDR_W{1'b0}}, push_ok}
                                               - {{eblk_pkg::ADDR_W{1'b0}}, pop_ok};
   wire logic [eblk_pkg::ADDR_W-1:0] wp_d =
      (wp_q == eblk_pkg::ADDR_W'(FDEPTH - 1)) ? '0 : wp_q + 13'h0001;
   wire logic [eblk_pkg::ADDR_W-1:0] rp_d =
      (rp_q == eblk_pkg::ADDR_W'(FDEPTH - 1)) ? '0 : rp_q + 13'h0001;

   // Effective word addresses: FIFO mode replaces the user addresses by the pointers.
   wire logic [eblk_pkg::ADDR_W-1:0] wa_a = FIFO ? wp_q : addr_a_q;
   wire logic [eblk_pkg::ADDR_W-1:0] ra_b = FIFO ? rp_q : addr_b_q;
   wire logic in_a = (32'(wa_a) < DEPTH_A);
   wire logic in_b = (32'(ra_b) < DEPTH_B);

   // word n starts at bit n times width
   wire logic [eblk_pkg::BASE_W-1:0] base_a = eblk_pkg::BASE_W'(32'(wa_a) * DW_A);
   wire logic [eblk_pkg::BASE_W-1:0] base_b = eblk_pkg::BASE_W'(32'(ra_b) * DW_B);
   wire logic [eblk_pkg::BASE_W-1:0] base_i =
      eblk_pkg::BASE_W'(32'(init_cnt_q) * eblk_pkg::INIT_DW);

   // in pseudo dual and FIFO modes port A writes only, port B reads only
   wire logic wr_a = ready_q && LEGAL && en_a_q && we_a_q && in_a && (FIFO ? push_ok : 1'b1);
   wire logic wr_b = ready_q && LEGAL && MULTI && !PDP && !FIFO && en_b_q && we_b_q && in_b;
   // A write cycle leaves the read data alone, so rdata only ever moves after a read.
   wire logic rd_a = ready_q && LEGAL && en_a_q && !we_a_q && !PDP && !FIFO && in_a;
   wire logic rd_b = ready_q && LEGAL && MULTI && en_b_q && (FIFO || PDP || !we_b_q) && in_b
                     && (FIFO ? pop_ok : 1'b1);
   wire logic init_wr = (state_q == eblk_pkg::EBLK_ST_LOAD) && flash_ack;
   wire logic init_end = init_wr && (init_cnt_q == eblk_pkg::INIT_LAST);

   // input registers on the port clock
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         en_a_q    <= 1'b0;
         we_a_q    <= 1'b0;
         addr_a_q  <= '0;
         wdata_a_q <= '0;
         en_b_q    <= 1'b0;
         we_b_q    <= 1'b0;
         addr_b_q  <= '0;
         wdata_b_q <= '0;
      end else begin
         en_a_q    <= en_a;
         we_a_q    <= we_a;
         addr_a_q  <= addr_a;
         wdata_a_q <= wdata_a;
         en_b_q    <= en_b;
         we_b_q    <= we_b;
         addr_b_q  <= addr_b;
         wdata_b_q <= wdata_b;
      end
   end

   // Reset clears the array, so an all-zero image costs no flash reads.
   // On a collision of both ports on one bit, port B writes last and wins.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_q <= '0;
      end else begin
         if (init_wr) begin
            mem_q[base_i +: eblk_pkg::INIT_DW] <= flash_data;
         end
         if (wr_a) begin
            mem_q[base_a +: DW_A] <= wdata_a_q;
         end
         if (wr_b) begin
            mem_q[base_b +: DW_B] <= wdata_b_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_q      <= INIT_FROM_FLASH ? eblk_pkg::EBLK_ST_LOAD : eblk_pkg::EBLK_ST_RUN;
         ready_q      <= !INIT_FROM_FLASH;
         flash_req_q  <= INIT_FROM_FLASH;
         init_cnt_q   <= '0;
         flash_addr_q <= INIT_IMAGE_BASE;
      end else begin
         case (state_q)
            eblk_pkg::EBLK_ST_LOAD: begin
               if (init_end) begin
                  state_q      <= eblk_pkg::EBLK_ST_RUN;
                  ready_q      <= 1'b1;
                  flash_req_q  <= 1'b0;
                  flash_addr_q <= flash_addr_q + 16'h0001;
               end else if (init_wr) begin
                  init_cnt_q   <= init_cnt_q + 13'h0001;
                  flash_addr_q <= flash_addr_q + 16'h0001;
               end
            end
            eblk_pkg::EBLK_ST_RUN: begin
               flash_req_q <= 1'b0;
            end
            default: begin
               state_q <= eblk_pkg::EBLK_ST_RUN;
            end
         endcase
      end
   end

   // FIFO level; a push seen while full or a pop while empty is dropped.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_q    <= '0;
         rp_q    <= '0;
         cnt_q   <= '0;
         full_q  <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         if (push_ok) begin
            wp_q <= wp_d;
         end
         if (pop_ok) begin
            rp_q <= rp_d;
         end
         cnt_q   <= cnt_d;
         full_q  <= (cnt_d == (eblk_pkg::ADDR_W + 1)'(FDEPTH));
         empty_q <= (cnt_d == '0);
      end
   end

   // Array read stage, then the optional output stage.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_a_q    <= '0;
         rd_b_q    <= '0;
         rdata_a_q <= '0;
         rdata_b_q <= '0;
      end else begin
         if (rd_a) begin
            rd_a_q <= mem_q[base_a +: DW_A];
         end
         if (rd_b) begin
            rd_b_q <= mem_q[base_b +: DW_B];
         end
         rdata_a_q <= rd_a_q;
         rdata_b_q <= rd_b_q;
      end
   end

   assign rdata_a    = OUT_REG_A ? rdata_a_q : rd_a_q;
   assign rdata_b    = OUT_REG_B ? rdata_b_q : rd_b_q;
   assign fifo_full  = full_q;
   assign fifo_empty = empty_q;
   assign ready      = ready_q;
   assign cfg_error  = !LEGAL;
   assign flash_req  = flash_req_q;
   assign flash_addr = flash_addr_q;
endmodule

// File: verif/eblk_ram_assertions.sv
// Port checker for the block RAM preload sequence and read timing.
module eblk_ram_checker #(
   parameter int unsigned DW_A            = 9,
   parameter int unsigned DW_B            = 9,
   parameter logic [15:0] INIT_IMAGE_BASE = 16'h0000
) (
   input wire logic                          clk,        // Clock
   input wire logic                          rst_n,      // Reset
   input wire logic                          en_a,       // Port A enable
   input wire logic                          we_a,       // Port A write
   input wire logic [DW_A-1:0]               rdata_a,    // Port A data
   input wire logic                          en_b,       // Port B enable
   input wire logic                          we_b,       // Port B write
   input wire logic [DW_B-1:0]               rdata_b,    // Port B data
   input wire logic                          ready,      // Ports live
   input wire logic                          cfg_error,  // Bad setup
   input wire logic                          flash_req,  // Preload request
   input wire logic [eblk_pkg::FLASH_AW-1:0] flash_addr, // Preload address
   input wire logic                          flash_ack   // Preload word
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_cfg_legal: assert property (!cfg_error)
      else $error("legal setup flagged as illegal");
   a_flash_step: assert property (flash_req && flash_ack |=> flash_addr == $past(flash_addr) + 16'h0001)
      else $error("preload address did not advance");
   a_flash_hold: assert property (flash_req && !flash_ack |=> $stable(flash_addr))
      else $error("preload address moved without a word");
   a_req_ready: assert property (flash_req |-> !ready)
      else $error("ports live during preload");
   a_ready_sticky: assert property (ready |=> ready && !flash_req)
      else $error("ready dropped or preload restarted");
   a_load_count: assert property ($fell(flash_req) |-> ready && flash_addr == INIT_IMAGE_BASE + 16'h0400)
      else $error("preload ended at the wrong word count");
   // The bench builds port A without and port B with the output register.
   a_rdata_a_cause: assert property ($changed(rdata_a) |-> $past(en_a & ~we_a, 2))
      else $error("port A data changed without a read two edges before");
   a_rdata_b_cause: assert property ($changed(rdata_b) |-> $past(en_b & ~we_b, 3))
      else $error("port B data changed without a read three edges before");
endmodule

bind eblk_ram eblk_ram_checker #(
   .DW_A            (DW_A),
   .DW_B            (DW_B),
   .INIT_IMAGE_BASE (INIT_IMAGE_BASE)
) u_chk (
   .clk(clk), .rst_n(rst_n), .en_a(en_a), .we_a(we_a), .rdata_a(rdata_a), .en_b(en_b),
   .we_b(we_b), .rdata_b(rdata_b), .ready(ready), .cfg_error(cfg_error),
   .flash_req(flash_req), .flash_addr(flash_addr), .flash_ack(flash_ack)
);

// File: verif/eblk_flash_model.sv
// User flash store model that feeds preload words to the block RAM.
module eblk_flash_model #(
   parameter logic [15:0] BASE = 16'h0000
) (
   input  wire logic        clk,        // Clock
   input  wire logic        slow,       // Answer every other cycle
   input  wire logic        flash_req,  // Preload request
   input  wire logic [15:0] flash_addr, // Preload address
   output logic             flash_ack,  // Word present
   output logic [8:0]       flash_data  // Preload word
);
   logic        phase_q = 1'b0;
   logic [8:0]  last_q  = 9'h000;
   logic [15:0] idx;
   logic [8:0]  word;
   // shared image: the word depends only on its offset from the base.
   assign idx = flash_addr - BASE;
   assign word = idx[8:0] ^ 9'h15a;
   assign flash_ack = flash_req & (~slow | phase_q);
   // Between words the data lines must not look like a valid word.
   assign flash_data = flash_ack ? word : ~last_q;
   always_ff @(posedge clk) begin
      phase_q <= ~phase_q & flash_req;
      if (flash_ack) begin
         last_q <= word;
      end
   end
endmodule

// File: verif/embedded_block_ram_tb.sv
// Self-checking bench: preload image, mixed-width mapping and refused accesses.
module embedded_block_ram_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] BASE = 16'h0100;
   typedef struct packed {
      logic [12:0] wa;
      logic [3:0]  wd;
      logic [12:0] rb;
      logic        exp;
   } eblk_row_s;
   eblk_row_s   rows [5] = '{'{13'h0005, 4'hc, 13'h0016, 1'b1}, '{13'h0005, 4'hc, 13'h0014, 1'b0},
      '{13'h07ff, 4'h9, 13'h1ffc, 1'b1}, '{13'h07ff, 4'h9, 13'h1ffd, 1'b0},
      '{13'h0000, 4'h6, 13'h0001, 1'b1}};
   int          pre [5] = '{0, 1, 2, 1023, 2047};
   logic        clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
   logic        en_a = 1'b0, we_a = 1'b0, en_b = 1'b0, we_b = 1'b0;
   logic [12:0] addr_a = 13'h0000, addr_b = 13'h0000;
   logic [3:0]  wdata_a = 4'h0, rdata_a;
   logic [0:0]  wdata_b = 1'b0, rdata_b;
   logic        ready, cfg_error, flash_req, flash_ack, fifo_full, fifo_empty;
   logic [15:0] flash_addr;
   logic [8:0]  flash_data;
   int          n_mismatch = 0, num_checks = 0;

   always #50 clk = ~clk;

   eblk_ram #(.MODE(eblk_pkg::EBLK_TRUE_DUAL), .DW_A(4), .DW_B(1), .OUT_REG_A(1'b0),
      .OUT_REG_B(1'b1), .INIT_FROM_FLASH(1'b1), .INIT_IMAGE_BASE(BASE)) dut (
      .clk(clk), .rst_n(rst_n), .en_a(en_a), .we_a(we_a), .addr_a(addr_a), .wdata_a(wdata_a),
      .rdata_a(rdata_a), .en_b(en_b), .we_b(we_b), .addr_b(addr_b), .wdata_b(wdata_b),
      .rdata_b(rdata_b), .fifo_full(fifo_full), .fifo_empty(fifo_empty), .ready(ready),
      .cfg_error(cfg_error), .flash_req(flash_req), .flash_addr(flash_addr),
      .flash_ack(flash_ack), .flash_data(flash_data));
   eblk_flash_model #(.BASE(BASE)) u_flash (.clk(clk), .slow(slow), .flash_req(flash_req),
      .flash_addr(flash_addr), .flash_ack(flash_ack), .flash_data(flash_data));

   function automatic logic img_bit(int b);
      logic [8:0] w;
      w = 9'(b / 9) ^ 9'h15a;
      return w[b % 9];
   endfunction
   function automatic logic [3:0] word_a(int n);
      logic [3:0] w;
      for (int k = 0; k < 4; k++) w[k] = img_bit(4 * n + k);
      return w;
   endfunction

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(string name, logic [3:0] exp, logic [3:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   // One access on both ports; waits until the registered B output has settled.
   task automatic op(logic wr, logic [12:0] aa, logic [3:0] da, logic [12:0] ab);
      @(posedge clk);
      en_a <= 1'b1;
      we_a <= wr;
      addr_a <= aa;
      wdata_a <= da;
      en_b <= 1'b1;
      addr_b <= ab;
      @(posedge clk);
      en_a <= 1'b0;
      we_a <= 1'b0;
      en_b <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wait_ready();
      int i;
      for (i = 0; i < 3000 && ready !== 1'b1; i++) @(posedge clk);
      #1;
      check("ready", 4'h1, {3'h0, ready});
      if (ready !== 1'b1) finish_test();
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      wait_ready();
      check("fifo flags", 4'h1, {2'h0, fifo_full, fifo_empty});
      check("cfg error", 4'h0, {3'h0, cfg_error});
      foreach (pre[i]) begin
         op(1'b0, 13'(pre[i]), 4'h0, 13'(8191 - pre[i]));
         check("preload a", word_a(pre[i]), rdata_a);
         check("preload b", {3'h0, img_bit(8191 - pre[i])}, {3'h0, rdata_b});
      end
      foreach (rows[i]) begin
         op(1'b1, rows[i].wa, rows[i].wd, rows[i].rb);
         op(1'b0, rows[i].wa, 4'h0, rows[i].rb);
         check("row a", rows[i].wd, rdata_a);
         check("row b", {3'h0, rows[i].exp}, {3'h0, rdata_b});
      end
      op(1'b1, 13'h0005, 4'h3, 13'h0014);
      check("old data b", 4'h0, {3'h0, rdata_b});
      op(1'b1, 13'h0800, 4'hf, 13'h0000);
      op(1'b0, 13'h0000, 4'h0, 13'h0000);
      check("no alias a", 4'h6, rdata_a);
      op(1'b0, 13'h0800, 4'h0, 13'h0000);
      check("range hold a", 4'h6, rdata_a);
      rst_n <= 1'b0;
      slow <= 1'b1;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      op(1'b1, 13'h0000, 4'hf, 13'h0000);
      wait_ready();
      op(1'b0, 13'h0000, 4'h0, 13'h0001);
      check("reload a", word_a(0), rdata_a);
      check("reload b", {3'h0, img_bit(1)}, {3'h0, rdata_b});
      finish_test();
   end
endmodule
